// [uxp_port.sv]
// External transceiver port: line drive/sense, suspend and port power.
// Assumes a serial engine beside it and a transceiver plus power switch outside.
`timescale 1ns/1ps
module uxp_port
   import uxp_pkg::*;
(
   // Clock and reset
   input  wire logic       CLK,
   input  wire logic       RESET_N,
   // Serial engine side
   input  wire logic       TX_ACTIVE,
   input  wire logic [1:0] TX_LINE,
   input  wire logic       PORT_POWER_REQ,
   input  wire logic       USB_SUSPENDED,
   output      logic       RX_BIT,
   output      logic [1:0] RX_LINE,
   output      logic       LINE_ERROR,
   output      logic       PORT_FAULT,
   output      logic       PORT_LOW_POWER,
   // Transceiver and power switch pins
   input  wire logic       port_overcurrent_n,
   input  wire logic       port_suspend_in,
   input  wire logic       xcvr_rx_bit,
   input  wire logic       line_sense_plus,
   input  wire logic       line_sense_minus,
   output      logic       port_power_on_n,
   output      logic       xcvr_drive_en_n,
   output      logic       xcvr_suspend_out,
   output      logic       line_drive_plus,
   output      logic       line_drive_minus
);
   logic [1:0] rst_sync_q;           // Reset release synchroniser
   wire        rst_n = rst_sync_q[1]; // Synchronised reset
   uxp_pwr_t   pwr_q;                 // Port power state
   uxp_pwr_t   pwr_d;                 // Next power state
   logic [1:0] drv_q;                 // Driven line code
   wire        low_power;             // Port forced into low power
   wire        may_drive;             // Transmission allowed
   wire [1:0]  drv_safe;              // Line code with 11 removed
   wire [1:0]  sense;                 // Sensed line code
   wire        tx_undef;              // Engine asked for the undefined code
   wire        sense_err;             // Both sense lines high at once
   wire        pwr_on_d;              // Power applied next cycle

   // Both lines high: undefined when driven, error when sensed
   function automatic logic is_both_high(input logic [1:0] code);
      return (code == SNS_ERR);
   endfunction

   // Reset release through two flops
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) rst_sync_q <= 2'h0;
      else rst_sync_q <= {rst_sync_q[0], 1'h1};
   end

   assign low_power = port_suspend_in | USB_SUSPENDED;
   assign may_drive = TX_ACTIVE & ~low_power;
   assign tx_undef = is_both_high(TX_LINE);
   assign drv_safe = tx_undef ? DRV_SE0 : TX_LINE;
   // Line sense inputs as one code
   assign sense = {line_sense_plus, line_sense_minus};
   // Error code on the sense lines
   assign sense_err = is_both_high(sense);
   // Power only in the on state
   assign pwr_on_d = (pwr_d == UXP_ON);

   // Power state selection
   always_comb begin
      pwr_d = pwr_q;
      case (pwr_q)
         UXP_OFF: if (PORT_POWER_REQ && port_overcurrent_n) pwr_d = UXP_ON;
         UXP_ON: begin
            if (!port_overcurrent_n) pwr_d = UXP_FAULT;
            else if (!PORT_POWER_REQ) pwr_d = UXP_OFF;
         end
         // Fault held until software drops request
         UXP_FAULT: if (!PORT_POWER_REQ) pwr_d = UXP_OFF;
         default: pwr_d = UXP_OFF;
      endcase
   end

   // Power state register
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         // Unpowered out of reset
         pwr_q <= UXP_OFF;
      end else begin
         pwr_q <= pwr_d;
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         // Port unpowered and no fault
         port_power_on_n <= RST_PWR_N;
         PORT_FAULT <= RST_FLAG;
      end else begin
         // Pin and flag track the next state
         port_power_on_n <= ~pwr_on_d;
         PORT_FAULT <= (pwr_d == UXP_FAULT);
      end
   end

   // Transmit path on the USB clock
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         xcvr_drive_en_n <= RST_DRV_EN_N;
         drv_q <= RST_DRV;
      end else begin
         xcvr_drive_en_n <= ~may_drive;
         drv_q <= may_drive ? drv_safe : DRV_ONE;
      end
   end
   assign line_drive_plus = drv_q[1];
   assign line_drive_minus = drv_q[0];

   // Suspend output and low power flag
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         // Awake out of reset
         xcvr_suspend_out <= RST_SUSP;
         PORT_LOW_POWER <= RST_SUSP;
      end else begin
         // Both drop as soon as suspend ends
         xcvr_suspend_out <= low_power;
         PORT_LOW_POWER <= low_power;
      end
   end

   // Receive bit and line state sampling
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         // Idle full-speed line, no error
         RX_BIT <= RST_RX_BIT;
         RX_LINE <= SNS_FS;
         LINE_ERROR <= RST_FLAG;
      end else begin
         // One cycle behind the pins
         RX_BIT <= xcvr_rx_bit;
         RX_LINE <= sense;
         LINE_ERROR <= sense_err;
      end
   end

   // Attempts that start in the last reset cycle are left out
   // Outputs there still hold reset values whatever the inputs say

   // Transmit side
   // Enable follows transmit request
   a_drive_enable: assert property (@(posedge CLK) disable iff (!rst_n)
      $past(TX_ACTIVE) == 1'h0 |-> xcvr_drive_en_n)
      else $error("drive enable low without transmit");
   a_drive_active: assert property (@(posedge CLK) disable iff (!rst_n)
      rst_n && TX_ACTIVE && !port_suspend_in && !USB_SUSPENDED |=> !xcvr_drive_en_n)
      else $error("drive enable high during transmit");
   a_drive_code: assert property (@(posedge CLK) disable iff (!rst_n)
      !(line_drive_plus && line_drive_minus))
      else $error("undefined line code driven");
   a_drive_follow: assert property (@(posedge CLK) disable iff (!rst_n)
      rst_n && TX_ACTIVE && !port_suspend_in && !USB_SUSPENDED && TX_LINE != SNS_ERR
      |=> {line_drive_plus, line_drive_minus} == $past(TX_LINE))
      else $error("driven code differs from request");
   // Idle pins rest on logic one
   a_drive_idle: assert property (@(posedge CLK) disable iff (!rst_n)
      xcvr_drive_en_n |-> {line_drive_plus, line_drive_minus} == DRV_ONE)
      else $error("idle drive code wrong");

   // Suspend and low power
   // No drive while suspended
   a_susp_quiet: assert property (@(posedge CLK) disable iff (!rst_n)
      xcvr_suspend_out |-> xcvr_drive_en_n)
      else $error("driving while suspended");
   a_susp_follow: assert property (@(posedge CLK) disable iff (!rst_n)
      rst_n && port_suspend_in |=> xcvr_suspend_out && PORT_LOW_POWER)
      else $error("suspend not applied");
   // Leave low power when suspend ends
   a_susp_leave: assert property (@(posedge CLK) disable iff (!rst_n)
      rst_n && !port_suspend_in && !USB_SUSPENDED |=> !xcvr_suspend_out && !PORT_LOW_POWER)
      else $error("low power kept after suspend");
   a_usb_susp: assert property (@(posedge CLK) disable iff (!rst_n)
      rst_n && USB_SUSPENDED |=> xcvr_suspend_out)
      else $error("suspend output missing");

   // Port power
   // Over-current removes power
   a_oc_cut: assert property (@(posedge CLK) disable iff (!rst_n)
      rst_n && !port_overcurrent_n |=> port_power_on_n)
      else $error("power kept on during over-current");
   a_fault_hold: assert property (@(posedge CLK) disable iff (!rst_n)
      rst_n && PORT_FAULT && PORT_POWER_REQ |=> PORT_FAULT && port_power_on_n)
      else $error("fault released too early");
   a_power_on: assert property (@(posedge CLK) disable iff (!rst_n)
      rst_n && pwr_q == UXP_OFF && PORT_POWER_REQ && port_overcurrent_n
      |=> !port_power_on_n)
      else $error("power not applied");
   a_power_off: assert property (@(posedge CLK) disable iff (!rst_n)
      rst_n && !PORT_POWER_REQ |=> port_power_on_n)
      else $error("power kept without request");

   // Receive side
   // Error decode
   a_sense_err: assert property (@(posedge CLK) disable iff (!rst_n)
      LINE_ERROR == (RX_LINE == SNS_ERR))
      else $error("line error decode wrong");
   a_sense_follow: assert property (@(posedge CLK) disable iff (!rst_n)
      $past(rst_n) |-> RX_LINE == {$past(line_sense_plus), $past(line_sense_minus)})
      else $error("sensed code not passed on");
   a_rx_sample: assert property (@(posedge CLK) disable iff (!rst_n)
      $past(rst_n) |-> RX_BIT == $past(xcvr_rx_bit))
      else $error("receive bit not sampled");

   // Main scenarios
   c_transmit: cover property (@(posedge CLK) disable iff (!rst_n) !xcvr_drive_en_n);
   c_fault: cover property (@(posedge CLK) disable iff (!rst_n) PORT_FAULT);
   c_suspend: cover property (@(posedge CLK) disable iff (!rst_n) xcvr_suspend_out);
   c_line_err: cover property (@(posedge CLK) disable iff (!rst_n) LINE_ERROR);
   c_power_on: cover property (@(posedge CLK) disable iff (!rst_n) !port_power_on_n);
endmodule // uxp_port

// [uxp_pkg.sv]
// Constants for the external USB transceiver port block.
// Assumes one 100 MHz clock; all pins synchronous to it.
// Contract
// - USB logic runs from the USB clock
// - Power enable low applies port power
// - Drive enable low only while transmitting
// - Suspend output high while USB suspended
// - Drive code: 00 SE0, 01 zero, 10 one
// - Decode sense lines: SE0, LS, FS, error
// - Receive bit sampled as serial stream
// - Port suspend high forces low power
package uxp_pkg;
   // Clock rate of the USB-side clock
   localparam int unsigned CLK_HZ = 100_000_000;
   // Drive line codes {plus, minus}
   localparam logic [1:0] DRV_SE0 = 2'h0;
   localparam logic [1:0] DRV_ZERO = 2'h1;
   localparam logic [1:0] DRV_ONE = 2'h2;
   // Sense line codes {plus, minus}
   localparam logic [1:0] SNS_SE0 = 2'h0;
   localparam logic [1:0] SNS_LS = 2'h1;
   localparam logic [1:0] SNS_FS = 2'h2;
   localparam logic [1:0] SNS_ERR = 2'h3;
   // Reset values of the outputs
   localparam logic RST_PWR_N = 1'h1;
   localparam logic RST_DRV_EN_N = 1'h1;
   localparam logic RST_SUSP = 1'h0;
   localparam logic [1:0] RST_DRV = DRV_ONE;
   localparam logic RST_RX_BIT = 1'h1;
   localparam logic RST_FLAG = 1'h0;
   // Port power states
   typedef enum logic [1:0] {UXP_OFF, UXP_ON, UXP_FAULT} uxp_pwr_t;
endpackage

// [uxp_xcvr_model.sv]
// Partner model: external transceiver and port power switch.
// Assumes the port block drives it and the bench sets the far bus state.
`timescale 1ns/1ps
module uxp_xcvr_model (
   // Pins from the port block
   input  wire logic       port_power_on_n,
   input  wire logic       xcvr_drive_en_n,
   input  wire logic [1:0] line_drive,
   // Bench controls
   input  wire logic       short_req,
   input  wire logic [1:0] bus_state,
   // Pins back to the port block
   output      logic       port_overcurrent_n,
   output      logic [1:0] line_sense,
   output      logic       xcvr_rx_bit
);
   // Low only for a short while powered
   assign port_overcurrent_n = ~(short_req & ~port_power_on_n);
   // Echo own drive while enabled, else far bus
   assign line_sense = xcvr_drive_en_n ? bus_state : line_drive;
   // Receiver follows the plus line
   assign xcvr_rx_bit = line_sense[1];
endmodule // uxp_xcvr_model

// [tb_top.sv]
// Bench for the transceiver port block beside its partner model.
// Assumes outputs settle one cycle after the inputs are sampled.
`timescale 1ns/1ps
module tb_top;
   import uxp_pkg::*;
   logic CLK = 0, RESET_N = 0, TX_ACTIVE = 0, PORT_POWER_REQ = 0, USB_SUSPENDED = 0;
   logic port_suspend_in = 0, short_req = 0, RX_BIT, LINE_ERROR, PORT_FAULT, PORT_LOW_POWER;
   logic port_overcurrent_n, port_power_on_n, xcvr_drive_en_n, xcvr_suspend_out, xcvr_rx_bit;
   logic [1:0] TX_LINE = 2'h0, bus_state = SNS_FS, RX_LINE;
   wire  [1:0] drv, sns;
   int mismatches = 0, check_count = 0;
   always #5 CLK = ~CLK;
   uxp_port i_uxp_port (.CLK, .RESET_N, .TX_ACTIVE, .TX_LINE, .PORT_POWER_REQ,
      .USB_SUSPENDED, .RX_BIT, .RX_LINE, .LINE_ERROR, .PORT_FAULT, .PORT_LOW_POWER,
      .port_overcurrent_n, .port_suspend_in, .xcvr_rx_bit, .line_sense_plus(sns[1]),
      .line_sense_minus(sns[0]), .port_power_on_n, .xcvr_drive_en_n, .xcvr_suspend_out,
      .line_drive_plus(drv[1]), .line_drive_minus(drv[0]));
   uxp_xcvr_model i_uxp_xcvr_model (.port_power_on_n, .xcvr_drive_en_n, .line_drive(drv),
      .short_req, .bus_state, .port_overcurrent_n, .line_sense(sns), .xcvr_rx_bit);
   // Compare and count
   task automatic chk(input logic [2:0] got, input logic [2:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got %b exp %b", $time, got, exp);
      end
   endtask
   // Wait edges, then let updates land
   task automatic tick(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask
   task automatic t_tx;
      for (int i = 0; i < 4; i++) begin
         @(posedge CLK) TX_ACTIVE <= 1;
         TX_LINE <= 2'(i);
         tick(1);
         chk({xcvr_drive_en_n, drv}, (i == 3) ? 3'h0 : 3'(i));
      end
      @(posedge CLK) TX_ACTIVE <= 0;
      tick(1);
      chk({xcvr_drive_en_n, drv}, {1'h1, RST_DRV});
      $display("tx codes done");
   endtask
   task automatic t_rx;
      for (int i = 0; i < 4; i++) begin
         @(posedge CLK) bus_state <= 2'(i);
         tick(1);
         chk({LINE_ERROR, RX_LINE}, {i == 3, 2'(i)});
         chk(RX_BIT, i[1]);
      end
      $display("rx codes done");
   endtask
   task automatic t_pwr;
      @(posedge CLK) PORT_POWER_REQ <= 1;
      tick(1);
      chk({port_power_on_n, PORT_FAULT}, 3'h0);
      @(posedge CLK) short_req <= 1;
      tick(1);
      chk({port_power_on_n, PORT_FAULT}, 3'h3);
      @(posedge CLK) short_req <= 0;
      tick(2);
      chk({port_power_on_n, PORT_FAULT}, 3'h3);
      @(posedge CLK) PORT_POWER_REQ <= 0;
      tick(1);
      chk({port_power_on_n, PORT_FAULT}, 3'h2);
      @(posedge CLK) PORT_POWER_REQ <= 1;
      tick(1);
      chk({port_power_on_n, PORT_FAULT}, 3'h0);
      $display("power done");
   endtask
   task automatic t_susp;
      @(posedge CLK) TX_ACTIVE <= 1;
      USB_SUSPENDED <= 1;
      tick(1);
      chk({xcvr_suspend_out, PORT_LOW_POWER, xcvr_drive_en_n}, 3'h7);
      @(posedge CLK) USB_SUSPENDED <= 0;
      port_suspend_in <= 1;
      tick(1);
      chk({xcvr_suspend_out, PORT_LOW_POWER, xcvr_drive_en_n}, 3'h7);
      @(posedge CLK) port_suspend_in <= 0;
      tick(1);
      chk({xcvr_suspend_out, PORT_LOW_POWER, xcvr_drive_en_n}, 3'h0);
      $display("suspend done");
   endtask
   // Mid-run reset with requests held, then release
   task automatic t_reset;
      @(posedge CLK) RESET_N <= 1'h0;
      tick(1);
      chk({port_power_on_n, xcvr_drive_en_n, xcvr_suspend_out}, 3'h6);
      chk({RX_BIT, RX_LINE}, {1'h1, SNS_FS});
      chk({LINE_ERROR, PORT_FAULT, PORT_LOW_POWER}, 3'h0);
      chk(drv, DRV_ONE);
      @(posedge CLK) RESET_N <= 1'h1;
      tick(2);
      chk({port_power_on_n, xcvr_drive_en_n, xcvr_suspend_out}, 3'h6);
      tick(1);
      chk({port_power_on_n, xcvr_drive_en_n, xcvr_suspend_out}, 3'h0);
      $display("reset done");
   endtask
   // Print counts and verdict
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Hang guard
   initial begin
      repeat (2000) @(posedge CLK);
      mismatches++;
      tally_and_finish();
   end
   // Main sequence
   initial begin
      tick(1);
      chk({port_power_on_n, xcvr_drive_en_n, xcvr_suspend_out}, 3'h6);
      @(posedge CLK) RESET_N <= 1;
      tick(3);
      t_tx();
      t_rx();
      t_pwr();
      t_susp();
      t_reset();
      tally_and_finish();
   end
endmodule // tb_top
